// ===== shared/wdtm_pkg.sv
package wdtm_pkg;
    // register byte offsets on the bus
    localparam logic [11:0] WDCTL_OFS = 12'h000;
    localparam logic [11:0] CKCTL_OFS = 12'h004;
    localparam logic [11:0] XIEN_OFS = 12'h008;
    localparam logic [11:0] GIEN_OFS = 12'h00C;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int STRB_LANE = 0;
    // watchdog_control_reg fields
    localparam int TFLAG_BIT = 3;
    localparam int RCAUSE_BIT = 2;
    localparam int REN_BIT = 1;
    localparam int RESTART_BIT = 0;
    // clock_control_reg interval field
    localparam int SEL_LSB = 6;
    localparam int SEL_MSB = 7;
    // interrupt enable bits
    localparam int WDIE_BIT = 4;
    localparam int GIE_BIT = 7;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [1:0] SEL_17 = 2'h0;
    localparam logic [1:0] SEL_20 = 2'h1;
    localparam logic [1:0] SEL_23 = 2'h2;
    // time-out intervals in system clocks
    localparam int unsigned TOUT0_CLKS = 131072;
    localparam int unsigned TOUT1_CLKS = 1048576;
    localparam int unsigned TOUT2_CLKS = 8388608;
    localparam int unsigned TOUT3_CLKS = 67108864;
    localparam int DIV_W = 26;
    // grace period and reset pulse length
    localparam int unsigned GRACE_CLKS = 512;
    localparam int unsigned MC_CLKS = 4;
    localparam int unsigned RST_MCYC = 2;
    localparam int unsigned RST_HOLD_CLKS = MC_CLKS * RST_MCYC;
    localparam int GCNT_W = 10;
    localparam logic [GCNT_W-1:0] GRACE_LAST = GCNT_W'(GRACE_CLKS - 1);
    localparam logic [GCNT_W-1:0] HOLD_LAST = GCNT_W'(RST_HOLD_CLKS - 1);
    typedef enum logic [1:0] {
        WDTM_IDLE,
        WDTM_GRACE,
        WDTM_HOLD
    } wdtm_state_t;
endpackage

// ===== hw/wdtm_div.sv
`timescale 1ns/1ps
module wdtm_div
    import wdtm_pkg::*;
#(
    parameter int unsigned TOUT0 = TOUT0_CLKS,
    parameter int unsigned TOUT1 = TOUT1_CLKS,
    parameter int unsigned TOUT2 = TOUT2_CLKS,
    parameter int unsigned TOUT3 = TOUT3_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic clr,
    input wire logic [1:0] sel,
    output logic [DIV_W-1:0] cnt_r,
    output logic tout_r
);
    logic [DIV_W-1:0] last;

    // terminal count of the selected tap
    always_comb begin
        case (sel)
            SEL_17: last = DIV_W'(TOUT0 - 1);
            SEL_20: last = DIV_W'(TOUT1 - 1);
            SEL_23: last = DIV_W'(TOUT2 - 1);
            default: last = DIV_W'(TOUT3 - 1);
        endcase
    end

    // free-running divider; >= so a shortened interval still wraps at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tout_r <= 1'b0;
        end else if (ce) begin
            if (clr) begin
                cnt_r <= '0; // see RULE_11
                tout_r <= 1'b0;
            end else if (cnt_r >= last) begin
                cnt_r <= '0; // see RULE_01
                tout_r <= 1'b1; // see RULE_02
            end else begin
                cnt_r <= cnt_r + 1'b1;
                tout_r <= 1'b0;
            end
        end
    end
endmodule // wdtm_div

// ===== hw/wdtm_rgen.sv
`timescale 1ns/1ps
module wdtm_rgen
    import wdtm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic tout,
    input wire logic cancel,
    input wire logic arm_en,
    output logic fire_r,
    output logic rst_r
);
    wdtm_state_t state_r;
    logic [GCNT_W-1:0] cnt_r;

    // grace countdown after a time-out, then the reset hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= WDTM_IDLE;
            cnt_r <= '0;
            fire_r <= 1'b0;
            rst_r <= 1'b0;
        end else if (ce) begin
            fire_r <= 1'b0;
            case (state_r)
                WDTM_IDLE: begin
                    cnt_r <= '0;
                    if (tout && !cancel) begin
                        state_r <= WDTM_GRACE;
                    end
                end
                WDTM_GRACE: begin
                    if (cancel) begin
                        state_r <= WDTM_IDLE; // see RULE_11
                    end else if (cnt_r == GRACE_LAST) begin
                        cnt_r <= '0;
                        if (arm_en) begin
                            state_r <= WDTM_HOLD; // see RULE_07
                            fire_r <= 1'b1;
                            rst_r <= 1'b1;
                        end else begin
                            state_r <= WDTM_IDLE; // see RULE_10
                        end
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                WDTM_HOLD: begin
                    if (cnt_r == HOLD_LAST) begin
                        state_r <= WDTM_IDLE; // see RULE_08
                        rst_r <= 1'b0;
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= WDTM_IDLE;
                end
            endcase
        end
    end
endmodule // wdtm_rgen

// ===== hw/wdtm_top.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
// Operation
// RULE_01 - the watchdog is a divider of the system clock that never stops.
// RULE_02 - interval codes 0..3 pick 2^17, 2^20, 2^23 or 2^26 clocks.
// RULE_03 - after reset the interval code is 0, the shortest time-out.
// RULE_04 - each elapsed interval sets the time-out flag, enabled or not.
// RULE_05 - interrupt when flag, watchdog enable and global enable are set.
// RULE_06 - the time-out flag clears on a software zero or on any reset.
// RULE_07 - with reset enabled, no restart for 512 clocks gives a reset.
// RULE_08 - that reset lasts two machine cycles and sets the cause flag.
// RULE_09 - the cause flag stays until cleared; untouched while disabled.
// RULE_10 - reset enable only gates the reset; the divider keeps running.
// RULE_11 - a restart write clears the divider and any pending countdown.
// RULE_12 - interrupt and reset paths are independent of one another.
// RULE_13 - power-fail disables the watchdog; its own reset restarts it.
// RULE_14 - reset enable, time-out flag and restart need timed access.
// RULE_15 - software should restart the timer before relying on it.
// RULE_16 - timed access is a one-cycle qualifier from the core.
module wdtm_top
    import wdtm_pkg::*;
#(
    parameter int unsigned TOUT0 = TOUT0_CLKS,
    parameter int unsigned TOUT1 = TOUT1_CLKS,
    parameter int unsigned TOUT2 = TOUT2_CLKS,
    parameter int unsigned TOUT3 = TOUT3_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [STRB_W-1:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ta_unlock,
    input wire logic pwr_fail,
    output logic irq,
    output logic sys_rst
);
    logic pf_s1_r;
    logic pf_s2_r;
    logic pready_r;
    logic [DATA_W-1:0] prdata_r;
    logic pslverr_r;
    logic ren_r;
    logic tflag_r;
    logic rcause_r;
    logic [1:0] sel_r;
    logic wdie_r;
    logic gie_r;
    logic irq_r;
    logic sys_rst_r;
    logic hit_wdctl;
    logic hit_ckctl;
    logic hit_xien;
    logic hit_gien;
    logic hit_any;
    logic setup;
    logic access;
    logic wr_lane;
    logic wr_wdctl;
    logic wr_prot;
    logic restart;
    logic div_clr;
    logic rg_cancel;
    logic fire;
    logic rg_rst;
    logic tout;
    logic [DIV_W-1:0] div_cnt;
    logic [DATA_W-1:0] rd_data;

    // power-fail is an async pin: two flops before anyone reads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_s1_r <= 1'b0;
            pf_s2_r <= 1'b0;
        end else if (ce) begin
            pf_s1_r <= pwr_fail;
            pf_s2_r <= pf_s1_r;
        end
    end

    // bus phases; writes land only at the completing access edge
    assign setup = psel && !penable;
    assign access = psel && penable && pready_r;
    assign wr_lane = access && pwrite && pstrb[STRB_LANE];

    // address decode
    always_comb begin
        hit_wdctl = 1'b0;
        hit_ckctl = 1'b0;
        hit_xien = 1'b0;
        hit_gien = 1'b0;
        if (paddr == WDCTL_OFS) begin
            hit_wdctl = 1'b1;
        end else if (paddr == CKCTL_OFS) begin
            hit_ckctl = 1'b1;
        end else if (paddr == XIEN_OFS) begin
            hit_xien = 1'b1;
        end else if (paddr == GIEN_OFS) begin
            hit_gien = 1'b1;
        end
    end
    assign hit_any = hit_wdctl || hit_ckctl || hit_xien || hit_gien;

    // protected writes need the unlock in the same cycle
    assign wr_wdctl = wr_lane && hit_wdctl;
    assign wr_prot = wr_wdctl && ta_unlock; // see RULE_14, see RULE_16
    assign restart = wr_prot && pwdata[RESTART_BIT]; // see RULE_11

    // any restart source clears the chain; own reset restarts too
    assign div_clr = restart || fire || pf_s2_r; // see RULE_13
    assign rg_cancel = restart || pf_s2_r;

    wdtm_div #(
        .TOUT0(TOUT0),
        .TOUT1(TOUT1),
        .TOUT2(TOUT2),
        .TOUT3(TOUT3)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clr(div_clr),
        .sel(sel_r),
        .cnt_r(div_cnt),
        .tout_r(tout)
    );

    wdtm_rgen u_rgen (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tout(tout),
        .cancel(rg_cancel),
        .arm_en(ren_r),
        .fire_r(fire),
        .rst_r(rg_rst)
    );

    // single wait-free access: ready follows the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else if (ce) begin
            pready_r <= setup;
        end
    end

    // read view; restart always reads back zero as it self-clears
    always_comb begin
        rd_data = '0;
        if (hit_wdctl) begin
            rd_data[TFLAG_BIT] = tflag_r;
            rd_data[RCAUSE_BIT] = rcause_r;
            rd_data[REN_BIT] = ren_r;
        end else if (hit_ckctl) begin
            rd_data[SEL_MSB:SEL_LSB] = sel_r;
        end else if (hit_xien) begin
            rd_data[WDIE_BIT] = wdie_r;
        end else if (hit_gien) begin
            rd_data[GIE_BIT] = gie_r;
        end
    end

    // read data and error are captured in setup, steady through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            if (setup) begin
                prdata_r <= pwrite ? '0 : rd_data;
                pslverr_r <= !hit_any;
            end else if (access) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // reset enable: power events or a protected write clear it, not the own reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ren_r <= 1'b0; // see RULE_13
        end else if (ce) begin
            if (pf_s2_r) begin
                ren_r <= 1'b0; // see RULE_13
            end else if (wr_prot) begin
                ren_r <= pwdata[REN_BIT]; // see RULE_10
            end
        end
    end

    // time-out flag: hardware set beats a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tflag_r <= 1'b0;
        end else if (ce) begin
            if (pf_s2_r || fire) begin
                tflag_r <= 1'b0; // see RULE_06
            end else if (tout) begin
                tflag_r <= 1'b1; // see RULE_04
            end else if (wr_prot) begin
                tflag_r <= pwdata[TFLAG_BIT]; // see RULE_06
            end
        end
    end

    // reset cause: only a fire sets it, and a fire needs reset enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcause_r <= 1'b0;
        end else if (ce) begin
            if (pf_s2_r) begin
                rcause_r <= 1'b0; // see RULE_09
            end else if (fire) begin
                rcause_r <= 1'b1; // see RULE_08
            end else if (wr_wdctl && !pwdata[RCAUSE_BIT]) begin
                rcause_r <= 1'b0; // see RULE_09
            end
        end
    end

    // interval select, back to shortest on every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= SEL_RST; // see RULE_03
        end else if (ce) begin
            if (pf_s2_r || fire) begin
                sel_r <= SEL_RST; // see RULE_03
            end else if (wr_lane && hit_ckctl) begin
                sel_r <= pwdata[SEL_MSB:SEL_LSB]; // see RULE_02
            end
        end
    end

    // interrupt enables, cleared by any reset like other core bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdie_r <= 1'b0;
            gie_r <= 1'b0;
        end else if (ce) begin
            if (pf_s2_r || fire) begin
                wdie_r <= 1'b0;
                gie_r <= 1'b0;
            end else begin
                if (wr_lane && hit_xien) begin
                    wdie_r <= pwdata[WDIE_BIT];
                end
                if (wr_lane && hit_gien) begin
                    gie_r <= pwdata[GIE_BIT];
                end
            end
        end
    end

    // interrupt ignores reset enable so both paths stand alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= tflag_r && wdie_r && gie_r; // see RULE_05, see RULE_12
        end
    end

    // system reset output, retimed so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_rst_r <= 1'b0;
        end else if (ce) begin
            sys_rst_r <= rg_rst; // see RULE_08
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign sys_rst = sys_rst_r;

    // checks hold only while the block is clocked
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);

    irq_follow_a: assert property ( // see RULE_05
        ##1 irq_r == $past(tflag_r && wdie_r && gie_r))
        else $error("irq does not follow flag and enables");

    tout_sets_a: assert property ( // see RULE_04
        tout && !fire && !pf_s2_r |=> tflag_r)
        else $error("time-out did not set the flag");

    flag_clear_a: assert property ( // see RULE_06
        wr_prot && !pwdata[TFLAG_BIT] && !tout |=> !tflag_r)
        else $error("software zero did not clear the flag");

    unprot_hold_a: assert property ( // see RULE_14
        wr_wdctl && !ta_unlock && !pf_s2_r |=> $stable(ren_r))
        else $error("unprotected write changed reset enable");

    // a restart inside the reset hold does not end the hold, so it is left out here
    restart_clr_a: assert property ( // see RULE_11
        restart && !rg_rst |=> div_cnt == '0 && !rg_rst)
        else $error("restart did not clear the divider");

    rst_len_a: assert property ( // see RULE_08
        $rose(sys_rst_r) |-> sys_rst_r[*8] ##1 !sys_rst_r)
        else $error("watchdog reset not eight clocks long");

    cause_set_a: assert property ( // see RULE_08
        $rose(sys_rst_r) |-> rcause_r)
        else $error("reset came without the cause flag");

    // $past counts raw clocks: a ce drop inside the grace window breaks it
    grace_time_a: assert property ( // see RULE_07
        fire |-> $past(tout, 513))
        else $error("reset not 512 clocks after time-out");

    cause_quiet_a: assert property ( // see RULE_09
        !ren_r |-> ##2 !$rose(rcause_r))
        else $error("cause flag moved while reset disabled");

    no_rst_off_a: assert property ( // see RULE_10
        !ren_r |-> ##2 !$rose(sys_rst_r))
        else $error("reset fired while disabled");

    pf_disable_a: assert property ( // see RULE_13
        pf_s2_r |=> !ren_r && !tflag_r && div_cnt == '0)
        else $error("power-fail did not disable the watchdog");

    timeout_c: cover property (tout);
    irq_c: cover property ($rose(irq_r));
    wdrst_c: cover property ($rose(sys_rst_r));
    cancel_c: cover property (restart && u_rgen.state_r == WDTM_GRACE);
    pfail_c: cover property ($rose(pf_s2_r));
endmodule // wdtm_top

// ===== tb/wdtm_top_test.sv
`timescale 1ns/1ps
module wdtm_top_test;
    import wdtm_pkg::*;
    // short intervals keep the run small; each exceeds the grace window
    localparam int unsigned T0 = 1000;
    localparam int unsigned T1 = 2000;
    localparam int unsigned T2 = 4000;
    localparam int unsigned T3 = 8000;
    localparam int unsigned TT[4] = '{T0, T1, T2, T3};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [STRB_W-1:0] pstrb = 4'hF;
    logic ta_unlock = 1'b0;
    logic pwr_fail = 1'b0;
    logic ce = 1'b1;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic sys_rst;
    logic [32:0] exp_q[$];
    logic [31:0] rs = 32'hAF9A835A;
    int n_errors = 0;
    int checked = 0;
    int n_rst = 0;
    int n;

    always #5 pclk = ~pclk;

    wdtm_top #(.TOUT0(T0), .TOUT1(T1), .TOUT2(T2), .TOUT3(T3)) dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ta_unlock(ta_unlock),
        .pwr_fail(pwr_fail), .irq(irq), .sys_rst(sys_rst)
    );

    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task automatic test_done();
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [32:0] seen,
                       input logic [32:0] expv);
        checked++;
        if (seen !== expv) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask

    // one apb transfer; a read leaves its expected {pslverr,prdata}
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic ta,
                       input logic [3:0] st, input logic [32:0] e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        ta_unlock <= ta;
        if (!wr)
            exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        ta_unlock <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic ta);
        apb(1'b1, a, d, ta, 4'hF, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, 1'b0, 4'hF, e);
    endtask

    // step one clock and look at outputs once they have settled
    task automatic tick();
        @(posedge pclk);
        #1;
    endtask

    // a wait that used its whole bound ends the run as a failure
    task automatic limit(input int got, input int lim);
        if (got >= lim) begin
            n_errors++;
            test_done();
        end
    endtask

    // read data is compared at the completing edge against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                chk("read note", 33'h0, 33'h1);
            end else begin
                chk("read", {pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    // counts watchdog reset cycles so quiet windows can be judged
    always @(posedge pclk) begin
        if (sys_rst === 1'b1)
            n_rst++;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(WDCTL_OFS, 33'h0);
        rd(CKCTL_OFS, 33'h0);
        rd(XIEN_OFS, 33'h0);
        rd(GIEN_OFS, 33'h0);
        rd(12'h010, {1'b1, 32'h0});
        wr(WDCTL_OFS, 32'h0000000A, 1'b0);
        rd(WDCTL_OFS, 33'h0);
        apb(1'b1, CKCTL_OFS, xs(), 1'b0, 4'h0, 33'h0);
        rd(CKCTL_OFS, 33'h0);
        // every interval code, restarted first, flag seen just around TT[c]
        for (int c = 0; c < 4; c++) begin
            wr(CKCTL_OFS, 32'(c) << SEL_LSB, 1'b0);
            rd(CKCTL_OFS, {1'b0, 32'(c) << SEL_LSB});
            wr(WDCTL_OFS, 32'h1, 1'b1);
            repeat (TT[c] - 30) @(posedge pclk);
            rd(WDCTL_OFS, 33'h0);
            repeat (60) @(posedge pclk);
            rd(WDCTL_OFS, 33'h8);
            wr(WDCTL_OFS, 32'h0, 1'b1);
            rd(WDCTL_OFS, 33'h0);
        end
        // interrupt and reset together; reset comes 512 clocks on
        wr(CKCTL_OFS, 32'h0, 1'b0);
        wr(XIEN_OFS, 32'h10, 1'b0);
        wr(GIEN_OFS, 32'h80, 1'b0);
        wr(WDCTL_OFS, 32'h3, 1'b1);
        n = 0;
        do begin
            tick();
            n++;
        end while (irq !== 1'b1 && n < 1200);
        limit(n, 1200);
        chk("irq", {32'h0, irq}, 33'h1);
        n = 0;
        do begin
            tick();
            n++;
        end while (sys_rst !== 1'b1 && n < 700);
        limit(n, 700);
        chk("grace", 33'(n), 33'd512);
        n = 0;
        do begin
            tick();
            n++;
        end while (sys_rst === 1'b1 && n < 50);
        limit(n, 50);
        chk("hold", 33'(n), 33'(RST_HOLD_CLKS));
        rd(WDCTL_OFS, 33'h6);
        rd(XIEN_OFS, 33'h0);
        // restart inside the grace window cancels the reset
        wr(XIEN_OFS, 32'h10, 1'b0);
        wr(GIEN_OFS, 32'h80, 1'b0);
        n = 0;
        do begin
            tick();
            n++;
        end while (irq !== 1'b1 && n < 1200);
        limit(n, 1200);
        repeat (300) @(posedge pclk);
        wr(WDCTL_OFS, 32'hF, 1'b1);
        n_rst = 0;
        repeat (600) @(posedge pclk);
        chk("no reset", 33'(n_rst), 33'h0);
        rd(WDCTL_OFS, 33'hE);
        chk("irq held", {32'h0, irq}, 33'h1);
        wr(WDCTL_OFS, 32'h0, 1'b0);
        rd(WDCTL_OFS, 33'hA);
        wr(GIEN_OFS, 32'h0, 1'b0);
        repeat (3) @(posedge pclk);
        chk("irq off", {32'h0, irq}, 33'h0);
        // reset disabled: flag still sets, no reset, cause untouched
        wr(WDCTL_OFS, 32'h1, 1'b1);
        n_rst = 0;
        // frozen clocks must not count toward the interval
        ce <= 1'b0;
        repeat (500) @(posedge pclk);
        ce <= 1'b1;
        repeat (T0 - 30) @(posedge pclk);
        rd(WDCTL_OFS, 33'h0);
        repeat (600) @(posedge pclk);
        chk("ren off", 33'(n_rst), 33'h0);
        rd(WDCTL_OFS, 33'h8);
        // power fail clears the enable and interval; the flags are already zero here
        wr(WDCTL_OFS, 32'h2, 1'b1);
        wr(CKCTL_OFS, 32'h40, 1'b0);
        @(posedge pclk);
        pwr_fail <= 1'b1;
        repeat (4) @(posedge pclk);
        pwr_fail <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(WDCTL_OFS, 33'h0);
        rd(CKCTL_OFS, 33'h0);
        repeat (3) @(posedge pclk);
        chk("queue", 33'(exp_q.size()), 33'h0);
        test_done();
    end
endmodule // wdtm_top_test
